// ### rtl/local_bus_ctrl.sv
// local bus controller: wait states, address wait, psram refresh, bus hold
// assumes requests come from logic on ref_clk_in; hold and standby are pins
// Operation
// (R1) 1M-byte range split in eight spaces, each configured on its own
// (R2) per-space wait count stretches the read or write strobe
// (R3) global address wait lengthens the address strobe
// (R4) pulse mode inserts periodic refresh cycles pulsing refresh request
// (R5) access to flagged space also pulses refresh request
// (R6) standby holds refresh request low steadily
// (R7) external master asserts hold request and waits for acknowledge
// (R8) on hold, finish current cycle then float bus outputs
// (R9) acknowledge hold only after outputs are floated
// (R10) while held, wait handling and periodic refresh generation are suspended
// (R11) hold release drops acknowledge and drives bus before next cycle
`timescale 1ns/1ps
module local_bus_ctrl
    import lbus_pkg::*;
#(
    parameter int REFRESH_PERIOD = 64
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // internal request side
    input wire logic req_valid_in,
    input wire req_type req_in,
    output logic req_accept_out,
    output logic done_out,
    output logic [DATA_W-1:0] rdata_out,
    // configuration levels
    input wire wait_cfg_type wait_cfg_in,
    input wire logic addr_wait_in,
    input wire logic pulse_refresh_en_in,
    input wire logic [SPACES-1:0] refresh_space_in,
    input wire logic standby_in,
    // bus pins
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe_out,
    output logic [DATA_W-1:0] ad_out,
    output logic ad_oe_out,
    input wire logic [DATA_W-1:0] ad_in,
    output logic address_latch_strobe_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic refresh_request_n_out,
    // bus hold
    input wire logic bus_hold_request_in,
    output logic bus_hold_acknowledge_out
);
    localparam int RC_W = $clog2(REFRESH_PERIOD + 1);
    localparam logic [RC_W-1:0] RC_LAST = RC_W'(REFRESH_PERIOD - 1);

    logic rst_n_a;
    logic rst_n;
    logic hold_q;
    logic standby_q;
    state_type state, next_state;
    pins_type pins, next_pins;
    req_type cur, next_cur;
    logic cur_aw, next_cur_aw;
    logic [WAIT_W-1:0] cur_wait, next_cur_wait;
    logic [WAIT_W-1:0] wcnt, next_wcnt;
    logic [RC_W-1:0] ref_cnt, next_ref_cnt;
    logic pending, next_pending;
    logic ack, next_ack;
    logic accept, next_accept;
    logic done, next_done;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic area_hit;

    // reset release through two flops
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_n_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_n_a <= 1'b1;
            rst_n <= rst_n_a;
        end
    end

    pin_sync #(.W(2)) u_sync (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .d_in({bus_hold_request_in, standby_in}),
        .q_out({hold_q, standby_q})
    );

    assign area_hit = refresh_space_in[space_of(cur.addr)];

    always_comb begin
        next_state = state;
        next_pins = pins;
        next_cur = cur;
        next_cur_aw = cur_aw;
        next_cur_wait = cur_wait;
        next_wcnt = wcnt;
        next_ref_cnt = ref_cnt;
        next_pending = pending;
        next_ack = ack;
        next_accept = 1'b0;
        next_done = 1'b0;
        next_rdata = rdata;
        // (R10) timer frozen while held
        if (pulse_refresh_en_in && !ack) begin
            next_ref_cnt = (ref_cnt == RC_LAST) ? '0 : ref_cnt + 1'b1;
        end
        case (state)
            ST_IDLE: begin
                next_pins.address_latch_strobe = 1'b0;
                // (R8) hold taken only between cycles
                if (hold_q) begin
                    next_state = ST_FLOAT;
                    next_pins.bus_oe = 1'b0;
                    next_pins.ad_oe = 1'b0;
                // (R4) periodic refresh cycle
                end else if (pending && pulse_refresh_en_in) begin
                    next_state = ST_REFRESH;
                    next_wcnt = WAIT_ZERO;
                    next_pending = 1'b0;
                end else if (req_valid_in && !standby_q) begin
                    // (R1) space picked from top address bits
                    next_cur = req_in;
                    next_cur_wait = wait_cfg_in[space_of(req_in.addr)];
                    next_cur_aw = addr_wait_in;
                    next_accept = 1'b1;
                    next_state = ST_ADDR;
                    next_pins.address_latch_strobe = 1'b1;
                    next_pins.addr = req_in.addr;
                    next_pins.ad = req_in.addr[DATA_W-1:0];
                    next_pins.ad_oe = 1'b1;
                end
            end
            ST_ADDR: begin
                // (R3) one extra address strobe cycle
                if (cur_aw) begin
                    next_state = ST_AWAIT;
                end else begin
                    next_state = ST_STROBE;
                    next_pins.address_latch_strobe = 1'b0;
                end
            end
            ST_AWAIT: begin
                next_state = ST_STROBE;
                next_pins.address_latch_strobe = 1'b0;
            end
            ST_FINISH: begin
                next_state = ST_IDLE;
                next_pins.ad_oe = 1'b0;
            end
            ST_REFRESH: begin
                next_wcnt = wcnt + 1'b1;
                if (wcnt == REFRESH_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FLOAT: begin
                // (R9) acknowledge one cycle after the float
                next_state = ST_HOLD;
                next_ack = 1'b1;
            end
            ST_HOLD: begin
                // (R11) release drives the pins again
                if (!hold_q) begin
                    next_state = ST_IDLE;
                    next_ack = 1'b0;
                    next_pins.bus_oe = 1'b1;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
        if (next_state == ST_STROBE && state != ST_STROBE) begin
            next_wcnt = WAIT_ZERO;
            next_pins.ad = cur.wdata;
            next_pins.ad_oe = cur.write;
        end
        if (state == ST_STROBE) begin
            // (R2) strobe lasts wait count plus one
            if (wcnt == cur_wait) begin
                next_state = ST_FINISH;
                next_done = 1'b1;
                next_rdata = cur.write ? rdata : ad_in;
            end else begin
                next_wcnt = wcnt + 1'b1;
            end
        end
        // (R5) refresh pulse folded into a flagged access
        if (next_state == ST_STROBE && area_hit) begin
            next_pending = 1'b0;
        end
        // set wins over clear
        if (pulse_refresh_en_in && !ack && ref_cnt == RC_LAST) begin
            next_pending = 1'b1;
        end
        next_pins.rd_n = !(next_state == ST_STROBE && !cur.write);
        next_pins.wr_n = !(next_state == ST_STROBE && cur.write);
        // (R6) steady low in standby, else pulse cycles
        next_pins.refresh_n = !(standby_q || next_state == ST_REFRESH
            || (next_state == ST_STROBE && area_hit && pulse_refresh_en_in));
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pins <= '{address_latch_strobe: 1'b0, rd_n: 1'b1, wr_n: 1'b1, bus_oe: 1'b1,
                ad_oe: 1'b0, refresh_n: 1'b1, addr: '0, ad: '0};
            cur <= '0;
            cur_aw <= 1'b0;
            cur_wait <= WAIT_ZERO;
            wcnt <= WAIT_ZERO;
            ref_cnt <= '0;
            pending <= 1'b0;
            ack <= 1'b0;
            accept <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
        end else begin
            state <= next_state;
            pins <= next_pins;
            cur <= next_cur;
            cur_aw <= next_cur_aw;
            cur_wait <= next_cur_wait;
            wcnt <= next_wcnt;
            ref_cnt <= next_ref_cnt;
            pending <= next_pending;
            ack <= next_ack;
            accept <= next_accept;
            done <= next_done;
            rdata <= next_rdata;
        end
    end

    assign req_accept_out = accept;
    assign done_out = done;
    assign rdata_out = rdata;
    assign addr_out = pins.addr;
    assign addr_oe_out = pins.bus_oe;
    assign ad_out = pins.ad;
    assign ad_oe_out = pins.ad_oe;
    assign address_latch_strobe_out = pins.address_latch_strobe;
    assign rd_n_out = pins.rd_n;
    assign wr_n_out = pins.wr_n;
    assign refresh_request_n_out = pins.refresh_n;
    assign bus_hold_acknowledge_out = ack;

    // helper: strobe length counter
    logic [WAIT_W:0] strobe_cnt;
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            strobe_cnt <= '0;
        end else begin
            strobe_cnt <= (!pins.rd_n || !pins.wr_n) ? strobe_cnt + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    AST_SPACE_PICK: assert property ( // (R1)
        state == ST_ADDR |-> cur_wait == wait_cfg_in[space_of(pins.addr)] || $changed(wait_cfg_in))
        else $error("wait count not taken from the addressed space");
    AST_STROBE_LEN: assert property ( // (R2)
        (pins.rd_n && pins.wr_n) && $past(!pins.rd_n || !pins.wr_n)
        |-> strobe_cnt == {1'b0, cur_wait} + 1'b1)
        else $error("strobe length differs from wait setting");
    AST_ADDR_WAIT: assert property ( // (R3)
        $fell(pins.address_latch_strobe) |-> (cur_aw ? $past(pins.address_latch_strobe, 2) : !$past(pins.address_latch_strobe, 2)))
        else $error("address strobe width wrong");
    AST_PULSE_REFRESH: assert property ( // (R4)
        state == ST_REFRESH |-> !pins.refresh_n && pins.rd_n && pins.wr_n ##1
        (state == ST_REFRESH || state == ST_IDLE))
        else $error("refresh cycle malformed");
    AST_AREA_REFRESH: assert property ( // (R5)
        state == ST_STROBE && area_hit && pulse_refresh_en_in |-> !pins.refresh_n)
        else $error("no refresh pulse on flagged access");
    AST_SELF_REFRESH: assert property ( // (R6)
        standby_q |=> !pins.refresh_n)
        else $error("refresh request not low in standby");
    AST_HOLD_FLOAT: assert property ( // (R8)
        ack |-> !pins.bus_oe && !pins.ad_oe && pins.rd_n && pins.wr_n)
        else $error("bus driven while held");
    AST_ACK_AFTER_FLOAT: assert property ( // (R9)
        $rose(ack) |-> $past(!pins.bus_oe) && $past(state) == ST_FLOAT)
        else $error("acknowledge before float");
    AST_HOLD_SUSPEND: assert property ( // (R10)
        ack && $past(ack) |-> ref_cnt == $past(ref_cnt) && !$rose(pending))
        else $error("refresh timer ran while held");
    AST_HOLD_RELEASE: assert property ( // (R11)
        $fell(ack) |-> pins.bus_oe && state == ST_IDLE && !$past(hold_q))
        else $error("release did not restore the bus");

    COV_READ: cover property (state == ST_STROBE && !cur.write ##1 done);
    COV_WRITE_AW: cover property (state == ST_AWAIT && cur.write);
    COV_REFRESH: cover property (state == ST_REFRESH);
    COV_HOLD: cover property ($fell(ack));
endmodule

// ### rtl/lbus_pkg.sv
// shared constants and carrier types for the local bus controller
// assumes a single 200 MHz clock domain and 20-bit external addresses
package lbus_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int SPACE_MSB = 19;
    localparam int SPACE_LSB = 17;
    localparam int SPACES = 8;
    localparam int WAIT_W = 2;
    localparam int CLK_MHZ = 200;
    localparam logic [WAIT_W-1:0] REFRESH_LAST = 2'h1;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 2'h0;
    localparam logic [WAIT_W-1:0] WAIT_ONE = 2'h1;

    typedef logic [SPACES-1:0][WAIT_W-1:0] wait_cfg_type;
    typedef logic [$clog2(SPACES)-1:0] space_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AWAIT = 3'b010,
        ST_STROBE = 3'b011,
        ST_FINISH = 3'b100,
        ST_REFRESH = 3'b101,
        ST_FLOAT = 3'b110,
        ST_HOLD = 3'b111
    } state_type;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_type;

    typedef struct packed {
        logic address_latch_strobe;
        logic rd_n;
        logic wr_n;
        logic bus_oe;
        logic ad_oe;
        logic refresh_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] ad;
    } pins_type;

    function automatic space_type space_of(input logic [ADDR_W-1:0] a);
        return a[SPACE_MSB:SPACE_LSB];
    endfunction
endpackage

// ### rtl/pin_sync.sv
// three-stage pin synchroniser; output moves when stages two and three agree
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // levels
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    always_comb begin
        next_q = q_out;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_q[i] = s2[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q_out <= '0;
        end else begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
            q_out <= next_q;
        end
    end
endmodule

// ### dv/lbus_partner.sv
// partner model: byte memory on the local bus plus an external bus master
// assumes bus pins of local_bus_ctrl, sampled on the rising clock edge
`timescale 1ns/1ps
module lbus_partner
    import lbus_pkg::*;
(
    // clock
    input wire logic clk_in,
    // bus pins from the controller
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic addr_oe_in,
    input wire logic [DATA_W-1:0] ad_in,
    input wire logic ad_oe_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    // bench controls
    input wire logic slow_in,
    input wire logic hold_go_in,
    // answers
    output logic [DATA_W-1:0] ad_out,
    output logic hold_req_out
);
    logic [DATA_W-1:0] mem [256];
    logic [DATA_W-1:0] last = 8'h00;
    logic rd_seen = 1'b0;
    logic rd_ok;
    // slow part is only good from the second strobe cycle
    assign rd_ok = !rd_n_in && addr_oe_in && (!slow_in || rd_seen);
    // released bus shows the inverse of its last value, never a stale copy
    assign ad_out = rd_ok ? mem[addr_in[7:0]] : ~last;
    always @(posedge clk_in) begin
        last <= ad_out;
        rd_seen <= !rd_n_in;
        if (!wr_n_in && addr_oe_in && ad_oe_in) begin
            mem[addr_in[7:0]] <= ad_in;
        end
        // request only; never drives the bus pins itself
        hold_req_out <= hold_go_in;
    end
endmodule

// ### dv/tb.sv
// self-checking bench for local_bus_ctrl
// assumes lbus_partner as memory and bus master, shortened refresh period
`timescale 1ns/1ps
module tb;
    import lbus_pkg::*;
    localparam int REF_P = 8;
    logic ref_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    req_type req_in = '0;
    wait_cfg_type wait_cfg_in = '0;
    logic addr_wait_in = 1'b0;
    logic pulse_refresh_en_in = 1'b0;
    logic [SPACES-1:0] refresh_space_in = '0;
    logic standby_in = 1'b0;
    logic slow = 1'b0;
    logic hold_go = 1'b0;
    logic hold_req, req_accept_out, done_out, addr_oe_out, ad_oe_out, address_latch_strobe_out;
    logic rd_n_out, wr_n_out, refresh_request_n_out, bus_hold_acknowledge_out;
    logic [DATA_W-1:0] rdata_out, ad_out, ad_in, mem_ad;
    logic [ADDR_W-1:0] addr_out;
    logic prev_ack = 1'b0;
    logic prev_oe = 1'b0;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    integer seed = 32'h67e2;

    // wire level of the shared address/data lines
    assign ad_in = ad_oe_out ? ad_out : mem_ad;

    local_bus_ctrl #(.REFRESH_PERIOD(REF_P)) local_bus_ctrl_inst (
        .ref_clk_in, .arst_n_in, .req_valid_in, .req_in, .req_accept_out, .done_out,
        .rdata_out, .wait_cfg_in, .addr_wait_in, .pulse_refresh_en_in, .refresh_space_in,
        .standby_in, .addr_out, .addr_oe_out, .ad_out, .ad_oe_out, .ad_in,
        .address_latch_strobe_out, .rd_n_out, .wr_n_out, .refresh_request_n_out,
        .bus_hold_request_in(hold_req), .bus_hold_acknowledge_out
    );
    lbus_partner lbus_partner_inst (
        .clk_in(ref_clk_in), .addr_in(addr_out), .addr_oe_in(addr_oe_out), .ad_in(ad_out),
        .ad_oe_in(ad_oe_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .slow_in(slow),
        .hold_go_in(hold_go), .ad_out(mem_ad), .hold_req_out(hold_req)
    );

    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic int exp_wait(input wait_cfg_type cfg, input logic [ADDR_W-1:0] a);
        return int'(cfg[a[SPACE_MSB:SPACE_LSB]]) + 1;
    endfunction

    // one bus cycle; counts strobe widths seen at the pins
    task automatic bus_op(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
        output int na, output int ns, output int nr);
        na = 0;
        ns = 0;
        nr = 0;
        req_valid_in <= 1'b1;
        req_in <= '{w, a, d};
        for (int n = 0; n < 200; n++) begin
            @(posedge ref_clk_in);
            if (req_accept_out === 1'b1) begin
                req_valid_in <= 1'b0;
            end
            if (address_latch_strobe_out === 1'b1) begin
                na++;
                chk(bus_hold_acknowledge_out, 1'b0);
                chk(addr_out, a);
                chk({ad_oe_out, ad_out}, {1'b1, a[DATA_W-1:0]});
            end
            if ((w ? wr_n_out : rd_n_out) === 1'b0) begin
                ns++;
                if (w) begin
                    chk({ad_oe_out, ad_out}, {1'b1, d});
                end
                nr += (refresh_request_n_out === 1'b0);
            end
            if (done_out === 1'b1) begin
                q = rdata_out;
                return;
            end
        end
        chk(1'b0, 1'b1);
    endtask

    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        int na, ns, nr, ew;
        ew = exp_wait(wait_cfg_in, a);
        bus_op(1'b1, a, d, q, na, ns, nr);
        chk(ns, ew);
        chk(na, 1 + addr_wait_in);
        bus_op(1'b0, a, 8'h00, q, na, ns, nr);
        chk(ns, ew);
        chk(q, d);
        chk(nr, (pulse_refresh_en_in && refresh_space_in[a[SPACE_MSB:SPACE_LSB]]) ? ew : 0);
    endtask

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        prev_ack <= bus_hold_acknowledge_out;
        prev_oe <= addr_oe_out | ad_oe_out;
        if (bus_hold_acknowledge_out === 1'b1) begin
            chk({addr_oe_out, ad_oe_out}, 2'b00);
            chk(refresh_request_n_out, 1'b1);
        end
        if (prev_ack !== 1'b1 && bus_hold_acknowledge_out === 1'b1) begin
            chk(prev_oe, 1'b0);
        end
        if (prev_ack === 1'b1 && bus_hold_acknowledge_out === 1'b0) begin
            chk(addr_oe_out, 1'b1);
        end
        if (cyc == 6000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        logic [DATA_W-1:0] q;
        int na, ns, nr, runs, len;
        repeat (8) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        chk({rd_n_out, wr_n_out, refresh_request_n_out, bus_hold_acknowledge_out}, 4'hE);
        // every wait count, with and without address wait
        for (int k = 0; k < 8; k++) begin
            wait_cfg_in <= {SPACES{k[1:0]}};
            addr_wait_in <= k[2];
            @(posedge ref_clk_in);
            wr_rd({k[2:0], 17'h10000 | 17'(k)}, 8'(k + 90));
        end
        for (int k = 0; k < 24; k++) begin
            wait_cfg_in <= wait_cfg_type'($random(seed));
            addr_wait_in <= 1'($random(seed));
            pulse_refresh_en_in <= 1'($random(seed));
            refresh_space_in <= SPACES'($random(seed));
            @(posedge ref_clk_in);
            wr_rd(ADDR_W'($random(seed)), DATA_W'($random(seed)));
        end
        // slow part relies on the inserted wait state
        slow <= 1'b1;
        wait_cfg_in <= {SPACES{WAIT_ONE}};
        @(posedge ref_clk_in);
        wr_rd(20'hE0077, 8'hA5);
        slow <= 1'b0;
        pulse_refresh_en_in <= 1'b1;
        runs = 0;
        len = 0;
        repeat (10 * REF_P) begin
            @(posedge ref_clk_in);
            if (refresh_request_n_out === 1'b0) begin
                len++;
                chk({rd_n_out, wr_n_out}, 2'b11);
            end else if (len != 0) begin
                chk(len, 2);
                runs++;
                len = 0;
            end
        end
        chk(runs >= 7, 1'b1);
        // hold raised while a cycle is under way
        hold_go <= 1'b1;
        bus_op(1'b1, 20'h00055, 8'h3C, q, na, ns, nr);
        chk(ns, exp_wait(wait_cfg_in, 20'h00055));
        for (int n = 0; n < 20 && bus_hold_acknowledge_out !== 1'b1; n++) begin
            @(posedge ref_clk_in);
        end
        chk(bus_hold_acknowledge_out, 1'b1);
        fork
            bus_op(1'b0, 20'h00055, 8'h00, q, na, ns, nr);
            begin
                repeat (6 * REF_P) @(posedge ref_clk_in);
                hold_go <= 1'b0;
            end
        join
        chk(q, 8'h3C);
        standby_in <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        repeat (4 * REF_P) begin
            @(posedge ref_clk_in);
            chk(refresh_request_n_out, 1'b0);
        end
        standby_in <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        wr_rd(20'h20011, 8'h96);
        close_out();
    end
endmodule
